// File: design/pfp_ctrl.sv
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pfp_ctrl (
  input  wire logic        aclk,    // Clock.
  input  wire logic        aresetn, // Synchronous reset, low active.
  input  wire logic        ce,      // Clock enable.
  pfp_link_if.ctrl         link,    // Link to power stage.
  input  wire logic        out_en_pin, // Output enable line from outside.
  input  wire logic [31:0] s_axi_awaddr,  // Write address.
  input  wire logic        s_axi_awvalid, // Write address valid.
  output logic             s_axi_awready, // Write address ready.
  input  wire logic [31:0] s_axi_wdata,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes.
  input  wire logic        s_axi_wvalid,  // Write data valid.
  output logic             s_axi_wready,  // Write data ready.
  output logic [1:0]       s_axi_bresp,   // Write response.
  output logic             s_axi_bvalid,  // Write response valid.
  input  wire logic        s_axi_bready,  // Write response ready.
  input  wire logic [31:0] s_axi_araddr,  // Read address.
  input  wire logic        s_axi_arvalid, // Read address valid.
  output logic             s_axi_arready, // Read address ready.
  output logic [31:0]      s_axi_rdata,   // Read data.
  output logic [1:0]       s_axi_rresp,   // Read response.
  output logic             s_axi_rvalid,  // Read data valid.
  input  wire logic        s_axi_rready,  // Read data ready.
  output logic             irq            // Level interrupt.
);
  typedef enum {PFP_RUN, PFP_SOFT, PFP_HARD} pfp_state_t;
  pfp_state_t state;

  logic [1:0]  ctrl;
  logic [6:0]  duty;
  logic [15:0] period, ocl;
  logic [pfp_pkg::ST_W-1:0] status, mask, ev;
  logic [pfp_pkg::FAULT_W-1:0] level;
  logic [15:0] pcnt, on_lim;
  logic [6:0]  ovl_cnt;
  logic        aw_hold, w_hold, poll_busy;
  logic [7:0]  aw_off;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [2:0]  en_sync;
  logic        en_prev;
  logic        en_toggle, wr_go, hard_ev, soft_ev, shut;
  logic        duty_cut, cut_now;

  // Output enable pin passes three flops; a change counts when the last two agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_sync <= 3'h0;
      en_prev <= 1'b0;
    end else if (ce) begin
      en_sync <= {en_sync[1:0], out_en_pin};
      if (en_sync[2] == en_sync[1]) en_prev <= en_sync[2];
    end
  end
  assign en_toggle = (en_sync[2] == en_sync[1]) && (en_sync[2] != en_prev);

  // Poll continuously: a new request two cycles after the last answer lands, one idle cycle between.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.poll_req <= 1'b0;
      poll_busy     <= 1'b0;
      level         <= pfp_pkg::FAULT_RST;
    end else if (ce) begin
      link.poll_req <= !poll_busy;
      poll_busy     <= poll_busy ? !link.poll_ack : 1'b1;
      if (link.poll_ack) level <= link.fault_word;
    end
  end

  // Overload counts cycles of summed current above the limit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovl_cnt <= 7'h00;
    end else if (ce) begin
      if ({8'h00, link.phase_avg} > ocl) begin
        if (ovl_cnt != 7'(pfp_pkg::OVL_CYCLES)) ovl_cnt <= ovl_cnt + 7'h01;
      end else begin
        ovl_cnt <= 7'h00;
      end
    end
  end

  assign hard_ev = link.poll_ack && (link.fault_word[pfp_pkg::BIT_OUT_HI] ||
                   link.fault_word[pfp_pkg::BIT_OUT_LOW] ||
                   link.fault_word[pfp_pkg::BIT_TEMP])
                   || (ovl_cnt == 7'(pfp_pkg::OVL_CYCLES));
  assign soft_ev = link.poll_ack && link.fault_word[pfp_pkg::BIT_IN_UV];

  // Shutdown state: hard faults only leave through reset, which stands for power cycling.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= PFP_RUN;
    end else if (ce) begin
      case (state)
        PFP_RUN: begin
          if (hard_ev) state <= PFP_HARD;
          else if (soft_ev) state <= PFP_SOFT;
        end
        PFP_SOFT: begin
          if (hard_ev) state <= PFP_HARD;
          else if (en_toggle) state <= PFP_RUN;
        end
        PFP_HARD: state <= PFP_HARD;
        default:  state <= PFP_HARD;
      endcase
    end
  end
  assign shut = (state != PFP_RUN) || !ctrl[0];

  // Switching period and duty limit; drives forced low in reset or shutdown.
  assign on_lim = 16'((32'(period) * 32'(duty)) / 32'd100);
  // Once cut, the upper switch stays off for the period, even if the limit is raised.
  assign cut_now = duty_cut && (pcnt != 16'h0000);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcnt             <= 16'h0000;
      duty_cut         <= 1'b0;
      link.cycle_start <= 1'b0;
      link.high_drive  <= 1'b0;
      link.low_side_drive <= 1'b0;
    end else if (ce) begin
      link.cycle_start <= (pcnt == 16'h0000);
      pcnt <= (pcnt + 16'h0001 >= period) ? 16'h0000 : pcnt + 16'h0001;
      duty_cut         <= cut_now || (pcnt >= on_lim);
      link.high_drive  <= !shut && !cut_now && (pcnt < on_lim);
      link.low_side_drive <= !shut && (cut_now || (pcnt >= on_lim));
    end
  end

  // Events for the sticky status register.
  always_comb begin
    ev = '0;
    ev[pfp_pkg::FAULT_W-1:0] = link.poll_ack ? link.fault_word : '0;
    ev[pfp_pkg::ST_OVL] = (ovl_cnt == 7'(pfp_pkg::OVL_CYCLES));
  end

  // AXI write: address and data taken in either order, response after both.
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_off  <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_off  <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; status set wins over a write-one clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl   <= 2'h1;
      duty   <= pfp_pkg::DUTY_RST;
      period <= pfp_pkg::PERIOD_RST;
      ocl    <= 16'h00ff;
      mask   <= '0;
      status <= '0;
    end else if (ce) begin
      status <= status | ev;
      if (wr_go && w_strb[0]) begin
        case (aw_off)
          pfp_pkg::REG_CTRL:   ctrl <= w_data[1:0];
          pfp_pkg::REG_DUTY:   duty <= w_data[6:0];
          pfp_pkg::REG_MASK:   mask <= w_data[pfp_pkg::ST_W-1:0];
          pfp_pkg::REG_STATUS: status <= (status & ~w_data[pfp_pkg::ST_W-1:0]) | ev;
          pfp_pkg::REG_OCLIM:  ocl[7:0] <= w_data[7:0];
          pfp_pkg::REG_PERIOD: period[7:0] <= w_data[7:0];
          default: ;
        endcase
      end
      if (wr_go && w_strb[1]) begin
        if (aw_off == pfp_pkg::REG_OCLIM) ocl[15:8] <= w_data[15:8];
        if (aw_off == pfp_pkg::REG_PERIOD) period[15:8] <= w_data[15:8];
      end
    end
  end
  assign irq = |(status & mask);

  // AXI read: one-cycle answer, held until rready.
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        case (s_axi_araddr[7:0])
          pfp_pkg::REG_CTRL:   s_axi_rdata <= {30'h0, ctrl};
          pfp_pkg::REG_DUTY:   s_axi_rdata <= {25'h0, duty};
          pfp_pkg::REG_STATUS: s_axi_rdata <= {27'h0, status};
          pfp_pkg::REG_MASK:   s_axi_rdata <= {27'h0, mask};
          pfp_pkg::REG_STATE:  s_axi_rdata <= {30'h0, state == PFP_HARD, state != PFP_RUN};
          pfp_pkg::REG_LEVEL:  s_axi_rdata <= {28'h0, level};
          pfp_pkg::REG_OCLIM:  s_axi_rdata <= {16'h0, ocl};
          pfp_pkg::REG_PERIOD: s_axi_rdata <= {16'h0, period};
          default:             s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : pfp_ctrl
`default_nettype wire

// File: design/pfp_pkg.sv
`default_nettype none
package pfp_pkg;
  // Fault register bit positions, one active-high bit per source.
  localparam int BIT_IN_UV   = 0;
  localparam int BIT_OUT_LOW = 1;
  localparam int BIT_OUT_HI  = 2;
  localparam int BIT_TEMP    = 3;
  localparam int FAULT_W     = 4;
  localparam logic [3:0] FAULT_RST = 4'h0;
  // Threshold codes: output offsets 0..225 mV in 7.5 mV steps, in tenths of mV.
  localparam int OV_STEP_TMV = 75;
  localparam int OV_MAX_TMV  = 2320;
  localparam int OV_CODE_MAX = OV_MAX_TMV / OV_STEP_TMV;
  localparam int OV_CODE_W   = 5;
  // Temperature trip 85..145 C in 10 C steps, 10 C hysteresis.
  localparam int TEMP_BASE_C = 85;
  localparam int TEMP_STEP_C = 10;
  localparam int TEMP_CODE_W = 3;
  localparam int TEMP_CODE_MAX = (145 - TEMP_BASE_C) / TEMP_STEP_C;
  localparam int TEMP_HYST_C = 10;
  // Input supply thresholds in 0.1 V units.
  localparam int VIN_RISE_DV = 91;
  localparam int VIN_FALL_DV = 76;
  localparam int PEAK_LEVELS = 4;
  localparam int PEAK_CODE_W = 2;
  // Controller registers (AXI4-Lite byte offsets).
  localparam logic [7:0] REG_CTRL   = 8'h00; // [0] enable, [1] stored and read back only, drives nothing
  localparam logic [7:0] REG_DUTY   = 8'h04; // [6:0] maximum duty percent
  localparam logic [7:0] REG_STATUS = 8'h08; // sticky, write one to clear
  localparam logic [7:0] REG_MASK   = 8'h0c;
  localparam logic [7:0] REG_STATE  = 8'h10; // [0] shut down, [1] latched hard
  localparam logic [7:0] REG_LEVEL  = 8'h14; // last polled fault word
  localparam logic [7:0] REG_OCLIM  = 8'h18; // overload limit on summed current
  localparam logic [7:0] REG_PERIOD = 8'h1c; // switching period in clocks
  localparam logic [6:0] DUTY_RST   = 7'h50;
  localparam logic [15:0] PERIOD_RST = 16'h0028;
  localparam int OVL_CYCLES = 64;
  // Status bits: four fault sources and overload.
  localparam int ST_W = 5;
  localparam int ST_OVL = 4;
endpackage : pfp_pkg
`default_nettype wire

// File: design/pfp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// Side bus between controller and power stage, plus the drive lines.
interface pfp_link_if;
  logic                         poll_req;    // Controller asks for the fault word.
  logic                         poll_ack;    // Stage answers, word valid.
  logic [pfp_pkg::FAULT_W-1:0]  fault_word;  // Polled fault register.
  logic                         high_drive;  // Upper switch pulse.
  logic                         low_side_drive; // Lower switch drive.
  logic                         cycle_start; // Start of switching period.
  logic [7:0]                   phase_avg;   // Average phase current.
  modport stage (input poll_req, high_drive, low_side_drive, cycle_start,
                 output poll_ack, fault_word, phase_avg);
  modport ctrl (output poll_req, high_drive, low_side_drive, cycle_start,
                input poll_ack, fault_word, phase_avg);
endinterface : pfp_link_if
`default_nettype wire

// File: design/pfp_hyst.sv
`timescale 1ns/1ns
`default_nettype none
// Hysteretic comparator: sets above hi, clears below lo, holds between.
module pfp_hyst #(
  parameter int W = 8
) (
  input  wire logic         aclk,    // Clock.
  input  wire logic         aresetn, // Synchronous reset, low active.
  input  wire logic         ce,      // Clock enable.
  input  wire logic [W-1:0] value,   // Measured quantity.
  input  wire logic [W-1:0] hi,      // Set threshold.
  input  wire logic [W-1:0] lo,      // Clear threshold.
  output logic              flag     // Held comparison result.
);
  // Hysteresis keeps the flag from chattering near the trip point.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (value > hi) flag <= 1'b1;
      else if (value < lo) flag <= 1'b0;
    end
  end
endmodule : pfp_hyst
`default_nettype wire

// File: design/pfp_stage.sv
`timescale 1ns/1ns
`default_nettype none
// Power stage fault monitor with peak current limit.
module pfp_stage (
  input  wire logic                          aclk,        // Clock.
  input  wire logic                          aresetn,     // Synchronous reset, low active.
  input  wire logic                          ce,          // Clock enable.
  pfp_link_if.stage                          link,        // Link to controller.
  input  wire logic [7:0]                    vin_dv,      // Supply in 0.1 V units.
  input  wire logic [7:0]                    filtered_sense_input, // Vout minus midpoint, signed code.
  input  wire logic [7:0]                    temp_c,      // Die temperature in C.
  input  wire logic [7:0]                    phase_i,     // Sensed phase current.
  input  wire logic [pfp_pkg::OV_CODE_W-1:0] ov_code,     // High offset code.
  input  wire logic [pfp_pkg::OV_CODE_W-1:0] uv_code,     // Low offset code.
  input  wire logic [pfp_pkg::TEMP_CODE_W-1:0] temp_code, // Trip code.
  input  wire logic [pfp_pkg::PEAK_CODE_W-1:0] peak_code, // One of four peak limits.
  output logic                               upper_on     // Gated upper switch.
);
  logic [pfp_pkg::FAULT_W-1:0] fault;
  logic [7:0] ov_mv, uv_mv, trip, peak_lim;
  logic       temp_hot, vin_low, peak_hit;
  logic signed [7:0] vs;

  // Clamp codes to their range and scale to mV (offset in 7.5 mV steps).
  always_comb begin
    ov_mv = 8'((int'(ov_code > 5'(pfp_pkg::OV_CODE_MAX) ? 5'(pfp_pkg::OV_CODE_MAX) : ov_code)
            * pfp_pkg::OV_STEP_TMV) / 10);
    uv_mv = 8'((int'(uv_code > 5'(pfp_pkg::OV_CODE_MAX) ? 5'(pfp_pkg::OV_CODE_MAX) : uv_code)
            * pfp_pkg::OV_STEP_TMV) / 10);
    trip = 8'(pfp_pkg::TEMP_BASE_C + pfp_pkg::TEMP_STEP_C *
           int'(temp_code > 3'(pfp_pkg::TEMP_CODE_MAX) ? 3'(pfp_pkg::TEMP_CODE_MAX) : temp_code));
    peak_lim = 8'h40 + {peak_code, 5'h00};
    vs = filtered_sense_input;
  end

  // Temperature flag trips at the setting and releases 10 C lower.
  pfp_hyst #(.W(8)) u_temp (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .value(temp_c), .hi(trip),
    .lo(8'(int'(trip) - pfp_pkg::TEMP_HYST_C)), .flag(temp_hot));

  // Supply flag: inverted codes turn the comparator round, so it sets below the falling
  // threshold and clears at or above the rising one. It starts clear, so a healthy supply at
  // reset raises no false input fault that would need an enable toggle to release.
  pfp_hyst #(.W(8)) u_vin (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .value(~vin_dv),
    .hi(~8'(pfp_pkg::VIN_FALL_DV)), .lo(~8'(pfp_pkg::VIN_RISE_DV - 1)),
    .flag(vin_low));

  // Fault register: one live active-high bit per source.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault <= pfp_pkg::FAULT_RST;
    end else if (ce) begin
      fault[pfp_pkg::BIT_IN_UV]   <= vin_low;
      fault[pfp_pkg::BIT_OUT_HI]  <= (vs > $signed({1'b0, ov_mv}));
      fault[pfp_pkg::BIT_OUT_LOW] <= (vs < -$signed({1'b0, uv_mv}));
      fault[pfp_pkg::BIT_TEMP]    <= temp_hot;
    end
  end

  // Answer a poll one cycle later with a registered word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.poll_ack   <= 1'b0;
      link.fault_word <= pfp_pkg::FAULT_RST;
      link.phase_avg  <= 8'h00;
    end else if (ce) begin
      link.poll_ack <= link.poll_req && !link.poll_ack;
      if (link.poll_req) link.fault_word <= fault;
      link.phase_avg <= phase_i;
    end
  end

  // Peak limit cuts the upper switch until the next period starts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_hit <= 1'b0;
    end else if (ce) begin
      if (link.cycle_start) peak_hit <= 1'b0;
      else if (phase_i > peak_lim) peak_hit <= 1'b1;
    end
  end
  assign upper_on = link.high_drive && !peak_hit && !(phase_i > peak_lim);
endmodule : pfp_stage
`default_nettype wire

// File: tb/pfp_link_props.sv
`timescale 1ns/1ns
`default_nettype none
// Checks the link between the controller and the stage.
module pfp_link_props (
  input wire logic                        aclk,           // Clock.
  input wire logic                        aresetn,        // Sync reset, low active.
  input wire logic                        poll_req,       // Poll request.
  input wire logic                        poll_ack,       // Poll answer.
  input wire logic [pfp_pkg::FAULT_W-1:0] fault_word,     // Polled faults.
  input wire logic                        high_drive,     // Upper pulse.
  input wire logic                        low_side_drive, // Lower drive.
  input wire logic                        cycle_start     // Period start.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Reset itself is the cause here, so this one is never disabled.
  property p_reset_low;
    disable iff (1'b0) !aresetn |=> !high_drive && !low_side_drive;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("drive on in reset");
  property p_ack_follows;
    poll_ack |-> $past(poll_req);
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack without poll");
  property p_ack_pulse;
    poll_ack |=> !poll_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_poll_live;
    1'b1 |-> ##[0:32] poll_ack;
  endproperty
  a_poll_live: assert property (p_poll_live) else $error("polling stopped");
  // A hard fault must switch everything off and keep it off for eight cycles.
  property p_hard_off;
    poll_ack && (|fault_word[3:1]) |-> ##[1:3] (!high_drive && !low_side_drive) [*8];
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("hard fault not shut");
  property p_soft_off;
    poll_ack && fault_word[pfp_pkg::BIT_IN_UV] |-> ##[1:3] !high_drive && !low_side_drive;
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("input fault not shut");
  property p_duty_wait;
    $fell(high_drive) |-> !high_drive until cycle_start;
  endproperty
  a_duty_wait: assert property (p_duty_wait) else $error("upper on mid period");
  property p_low_bound;
    low_side_drive |-> ##[1:300] (cycle_start || !low_side_drive);
  endproperty
  a_low_bound: assert property (p_low_bound) else $error("period never ends");
  property p_cycle_gap;
    cycle_start |=> (!cycle_start) [*8];
  endproperty
  a_cycle_gap: assert property (p_cycle_gap) else $error("period too short");
  property p_no_overlap;
    !(high_drive && low_side_drive);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches on");
endmodule : pfp_link_props
`default_nettype wire

// File: tb/power_stage_fault_protection_test.sv
`timescale 1ns/1ns
`default_nettype none
module power_stage_fault_protection_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        out_en = 1'b0;
  logic [7:0]  vin = 8'h78, sense = 8'h00, temp_c = 8'h28, phase_i = 8'h10;
  logic [4:0]  ov_code = 5'h00, uv_code = 5'h00;
  logic [2:0]  t_code = 3'h0;
  logic [1:0]  pk_code = 2'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, upper_on, irq;
  logic [1:0]  bresp, rresp;
  int          n_errors = 0, checks_done = 0, seed = 35;
  pfp_link_if lk ();
  // The clock toggles every half period of 25 ns.
  always #25 aclk = ~aclk;
  pfp_stage i_pfp_stage (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(lk), .vin_dv(vin),
    .filtered_sense_input(sense), .temp_c(temp_c), .phase_i(phase_i), .ov_code(ov_code),
    .uv_code(uv_code), .temp_code(t_code), .peak_code(pk_code), .upper_on(upper_on));
  pfp_ctrl i_pfp_ctrl (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(lk), .out_en_pin(out_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  pfp_link_props i_pfp_link_props (.aclk(aclk), .aresetn(aresetn), .poll_req(lk.poll_req),
    .poll_ack(lk.poll_ack), .fault_word(lk.fault_word), .high_drive(lk.high_drive),
    .low_side_drive(lk.low_side_drive), .cycle_start(lk.cycle_start));
  task automatic conclude;
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    chk_word("bresp", 32'h0, {30'h0, bresp});
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk_word("rresp", 32'h0, {30'h0, rresp});
    chk_word(nm, e, rdata);
  endtask : rd_chk
  task automatic wait_irq(input logic lvl);
    for (int k = 0; k < 300 && irq !== lvl; k++) @(posedge aclk);
    chk_bit("irq", lvl, irq);
  endtask : wait_irq
  task automatic wait_start;
    do @(posedge aclk); while (lk.cycle_start !== 1'b1);
  endtask : wait_start
  // Reset is held eight cycles, then healthy conditions come back.
  task automatic do_reset;
    aresetn <= 1'b0;
    tick(8);
    aresetn <= 1'b1;
    {vin, sense, temp_c, phase_i} <= {8'h78, 8'h00, 8'h28, 8'h10};
    @(posedge aclk);
    wr(pfp_pkg::REG_MASK, 32'h1f);
  endtask : do_reset
  task automatic toggle_en;
    out_en <= 1'b1;
    tick(10);
    out_en <= 1'b0;
    tick(10);
  endtask : toggle_en
  // A hang counts as a mismatch and still ends the run in one place.
  initial begin
    tick(30000);
    n_errors++;
    conclude;
  end
  // Main sequence: reset values, duty, peak limit, input fault, latched faults.
  initial begin
    int p, d, n, c, t;
    int pos[4];
    logic [7:0] lim;
    pos = '{pfp_pkg::BIT_OUT_LOW, pfp_pkg::BIT_OUT_HI, pfp_pkg::BIT_TEMP, pfp_pkg::ST_OVL};
    @(posedge aclk);
    do_reset;
    rd_chk("duty", pfp_pkg::REG_DUTY, 32'h50);
    rd_chk("period", pfp_pkg::REG_PERIOD, 32'h28);
    rd_chk("oclim", pfp_pkg::REG_OCLIM, 32'hff);
    rd_chk("status", pfp_pkg::REG_STATUS, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    p = 20 + ($unsigned($random(seed)) % 41);
    d = 20 + ($unsigned($random(seed)) % 71);
    wr(pfp_pkg::REG_PERIOD, 32'(p));
    wr(pfp_pkg::REG_DUTY, 32'(d));
    wait_start;
    wait_start;
    n = 0;
    // Any window of one period holds the same count of on cycles.
    repeat (p) begin
      if (lk.high_drive === 1'b1) n++;
      @(posedge aclk);
    end
    chk_word("on_cycles", 32'(p * d / 100), 32'(n));
    for (int pc = 0; pc < 4; pc++) begin
      lim = 8'(8'h40 + 32 * pc);
      pk_code <= 2'(pc);
      for (int ab = 1; ab >= 0; ab--) begin
        phase_i <= lim + 8'(ab);
        wait_start;
        wait_start;
        tick(2);
        chk_bit("upper_on", !ab, upper_on);
      end
    end
    // A one-cycle spike must keep the upper switch off after the current drops again.
    wait_start;
    phase_i <= 8'hff;
    tick(1);
    phase_i <= 8'h10;
    tick(1);
    chk_bit("upper_hold", 1'b0, upper_on);
    vin <= 8'd70;
    wait_irq(1'b1);
    rd_chk("status", pfp_pkg::REG_STATUS, 32'h01);
    rd_chk("state", pfp_pkg::REG_STATE, 32'h1);
    chk_bit("drive", 1'b0, lk.high_drive | lk.low_side_drive);
    wr(pfp_pkg::REG_MASK, 32'h1e);
    wait_irq(1'b0);
    wr(pfp_pkg::REG_MASK, 32'h1f);
    vin <= 8'd80;
    tick(40);
    rd_chk("level", pfp_pkg::REG_LEVEL, 32'h1);
    vin <= 8'd95;
    tick(40);
    rd_chk("level", pfp_pkg::REG_LEVEL, 32'h0);
    wr(pfp_pkg::REG_STATUS, 32'h01);
    wait_irq(1'b0);
    rd_chk("state", pfp_pkg::REG_STATE, 32'h1);
    toggle_en;
    rd_chk("state", pfp_pkg::REG_STATE, 32'h0);
    // Sense codes stay below 16 because the signed sense input tops out at 127 mV.
    for (int k = 0; k < 4; k++) begin
      do_reset;
      c = (k == 1) ? 15 : $unsigned($random(seed)) % 16;
      t = $unsigned($random(seed)) % 7;
      ov_code <= 5'(c);
      uv_code <= 5'(15 - c);
      t_code <= 3'(t);
      case (k)
        0: sense <= 8'(-((15 - c) * 75 / 10 + 1));
        1: sense <= 8'(c * 75 / 10 + 1);
        2: temp_c <= 8'(86 + 10 * t);
        default: begin
          wr(pfp_pkg::REG_OCLIM, 32'h20);
          phase_i <= 8'h30;
        end
      endcase
      wait_irq(1'b1);
      rd_chk("status", pfp_pkg::REG_STATUS, 32'h1 << pos[k]);
      rd_chk("state", pfp_pkg::REG_STATE, 32'h3);
      if (k == 2) begin
        temp_c <= 8'(80 + 10 * t);
        tick(40);
        rd_chk("level", pfp_pkg::REG_LEVEL, 32'h8);
        temp_c <= 8'(74 + 10 * t);
        tick(40);
        rd_chk("level", pfp_pkg::REG_LEVEL, 32'h0);
      end
      {sense, temp_c, phase_i} <= {8'h00, 8'h28, 8'h10};
      toggle_en;
      wr(pfp_pkg::REG_STATUS, 32'h1f);
      rd_chk("state", pfp_pkg::REG_STATE, 32'h3);
      chk_bit("drive", 1'b0, lk.high_drive | lk.low_side_drive);
    end
    conclude;
  end
endmodule : power_stage_fault_protection_test
`default_nettype wire
